//--- logic/uab_core.sv
// Serial transceiver core: pin-level register bus, baud divider, transmit FIFO, transmitter,
// receiver, modem lines and interrupt identification.
// Assumes all pins except rst_n_i are asynchronous to core_clk_i and strobes last at least three clocks.
`timescale 1ns/1ps
`default_nettype none
`include "uab_regs.svh"

// Transmit FIFO; depth must be a power of two so the pointers wrap on their own.
module uab_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic         clr_i,
    input  wire logic         in_valid_i,
    input  wire logic [W-1:0] in_data_i,
    output logic              in_ready_o,
    output logic              out_valid_o,
    output logic [W-1:0]      out_data_o,
    input  wire logic         out_ready_i
);
    localparam int AW = $clog2(D);
    logic [W-1:0]  mem_q [D];
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [AW:0]   cnt_q, cnt_d;
    logic          push, pop;

    // Full and empty come straight from the count so they never lie.
    assign in_ready_o  = cnt_q != (AW+1)'(D);
    assign out_valid_o = cnt_q != '0;
    assign out_data_o  = mem_q[rp_q];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    // Pointer and count update; a clear wins over a simultaneous push or pop.
    always_comb begin
        wp_d  = clr_i ? '0 : wp_q + AW'(push);
        rp_d  = clr_i ? '0 : rp_q + AW'(pop);
        cnt_d = clr_i ? '0 : cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end

    // Storage and pointers.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            cnt_q <= cnt_d;
        end
        if (push && !clr_i) begin
            mem_q[wp_q] <= in_data_i;
        end
    end
endmodule : uab_fifo

module uab_core #(
    parameter int TX_DEPTH = 8
) (
    input  wire logic       core_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       chip_select_n_i,
    input  wire logic [2:0] addr_i,
    input  wire logic [7:0] data_i,
    output logic      [7:0] data_o,
    output logic            data_oe_o,
    input  wire logic       read_strobe_n_i,
    input  wire logic       write_strobe_n_i,
    output logic            bus_driver_disable_n_o,
    input  wire logic       rxd_i,
    output logic            txd_o,
    input  wire logic       cts_n_i,
    input  wire logic       dsr_n_i,
    input  wire logic       ri_n_i,
    input  wire logic       cd_n_i,
    output logic            rts_n_o,
    output logic            dtr_n_o,
    output logic            user_output_one_n_o,
    output logic            user_output_two_n_o,
    output logic            int_o,
    output logic            recv_dma_ready_n_o,
    output logic            xmit_dma_ready_n_o
);
    import uab_pkg::*;

    // Parity bit for a word of the current length; forced parity overrides the data.
    function automatic logic parity_bit(input logic [7:0] d, input logic [7:0] lc);
        return lc[5] ? ~lc[4] : (^(d & (8'hFF >> (2'd3 - lc[1:0])))) ^ ~lc[4];
    endfunction : parity_bit

    logic [18:0] s1_q, s2_q, s3_q;
    logic        cs2, rd2, wr2, rx2, cs3, rd3, wr3;
    logic [2:0]  a2, a3;
    logic [7:0]  d3;
    logic [3:0]  mod2;
    logic [3:0]  ier_q, ier_d, msd_q, msd_d, msp_q, msp_d, ph_q, ph_d, tcnt_q, tcnt_d, rcnt_q, rcnt_d;
    logic [7:0]  lcr_q, lcr_d, fcr_q, fcr_d, scr_q, scr_d, rhr_q, rhr_d, dout_q, dout_d;
    logic [7:0]  tsh_q, tsh_d, rsh_q, rsh_d, rxw, isr_w, lsr_w, msr_w, fdata;
    logic [4:0]  mcr_q, mcr_d;
    logic [15:0] div_q, div_d, bcnt_q, bcnt_d;
    logic [2:0]  tbit_q, tbit_d, rbit_q, rbit_d, last_bit;
    logic        dr_q, dr_d, oe_q, oe_d, pe_q, pe_d, fe_q, fe_d, bi_q, bi_d, thri_q, thri_d;
    logic        te_q, te_d, mval_q, mval_d, rdy_q, rdy_d, tpar_q, tpar_d, rpar_q, rpar_d;
    logic        txd_q, txd_d, tick, loop, rxs, rd_ev, wr_ev, dlab, m1, rx_done;
    logic        fpush, fclr, fready, fvalid, fpop, thr_wr;
    logic [3:0]  mcur, iid;
    uab_tx_t     tst_q, tst_d;
    uab_rx_t     rst_q, rst_d;

    // Every pin except rst_n_i passes two flops; a third stage serves the strobe edge detectors and the write chip select, address and data.
    // The modem inputs keep sampling through reset, so the change detector does not
    // mistake an already active modem line for a fresh change right after release.
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            s1_q[18:4] <= 15'h7FFF;
            s2_q[18:4] <= 15'h7FFF;
            s3_q       <= 19'h7FFFF;
        end else begin
            s1_q[18:4] <= {chip_select_n_i, read_strobe_n_i, write_strobe_n_i, addr_i, data_i, rxd_i};
            s2_q[18:4] <= s1_q[18:4];
            s3_q       <= s2_q;
        end
        s1_q[3:0] <= {cd_n_i, ri_n_i, dsr_n_i, cts_n_i};
        s2_q[3:0] <= s1_q[3:0];
    end
    assign {cs2, rd2, wr2, a2} = s2_q[18:13];
    assign {rx2, mod2}         = s2_q[4:0];
    assign {cs3, rd3, wr3, a3, d3}            = s3_q[18:5];

    // Reads act on the leading strobe edge; writes on the trailing edge, using the last
    // sample taken while the strobe was low, since data setup is only guaranteed there.
    assign rd_ev = ~cs2 & ~rd2 & rd3;
    assign wr_ev = ~cs3 & wr2 & ~wr3;
    assign dlab  = lcr_q[7];
    assign loop  = mcr_q[4];
    assign m1    = fcr_q[0] & fcr_q[3];
    assign tick  = bcnt_q == 16'h0001;
    assign rxs   = loop ? txd_q : rx2;
    assign mcur  = loop ? {mcr_q[3], mcr_q[2], mcr_q[0], mcr_q[1]} : ~mod2;
    assign thr_wr = wr_ev && a3 == `UAB_OFF_DATA && !dlab;
    assign fpush = thr_wr & (fcr_q[0] | ~fvalid);
    assign fclr  = wr_ev && a3 == `UAB_OFF_IID && d3[2];
    assign fpop  = tst_q == TX_IDLE;
    assign last_bit = 3'd4 + {1'b0, lcr_q[1:0]};
    assign rxw   = rsh_q >> (2'd3 - lcr_q[1:0]);

    uab_fifo #(.W(8), .D(TX_DEPTH)) u_txq (
        .clk_i       (core_clk_i),
        .rst_n_i     (rst_n_i),
        .clr_i       (fclr),
        .in_valid_i  (fpush),
        .in_data_i   (d3),
        .in_ready_o  (fready),
        .out_valid_o (fvalid),
        .out_data_o  (fdata),
        .out_ready_i (fpop)
    );

    // Interrupt identification in fixed priority: line, receive, transmit, modem.
    always_comb begin
        if (ier_q[2] && (oe_q || pe_q || fe_q || bi_q)) iid = `UAB_IID_LINE;
        else if (ier_q[0] && dr_q)                       iid = `UAB_IID_RXD;
        else if (ier_q[1] && thri_q)                     iid = `UAB_IID_THR;
        else if (ier_q[3] && msd_q != 4'h0)              iid = `UAB_IID_MODEM;
        else                                             iid = `UAB_IID_NONE;
    end
    assign isr_w = {fcr_q[0], fcr_q[0], 2'b00, iid};
    assign lsr_w = {fcr_q[0] & (pe_q | fe_q | bi_q), ~fvalid & (tst_q == TX_IDLE), ~fvalid,
                    bi_q, fe_q, pe_q, oe_q, dr_q};
    assign msr_w = {mcur, msd_q};

    // Next state of everything; bus clears come first so hardware events set last and win.
    always_comb begin
        {ier_d, lcr_d, mcr_d, fcr_d, scr_d, div_d, dout_d} = {ier_q, lcr_q, mcr_q, fcr_q, scr_q, div_q, dout_q};
        {rhr_d, dr_d, oe_d, pe_d, fe_d, bi_d, thri_d} = {rhr_q, dr_q, oe_q, pe_q, fe_q, bi_q, thri_q};
        {tst_d, tsh_d, tpar_d, tbit_d, tcnt_d} = {tst_q, tsh_q, tpar_q, tbit_q, tcnt_q};
        {rst_d, rsh_d, rpar_d, rbit_d, rcnt_d} = {rst_q, rsh_q, rpar_q, rbit_q, rcnt_q};
        msd_d   = msd_q;
        msp_d   = mcur;
        mval_d  = 1'b1;
        rdy_d   = 1'b1;
        te_d    = ~fvalid;
        rx_done = 1'b0;
        // The divider reloads on its terminal count, giving one tick per divisor clocks.
        bcnt_d  = tick ? div_q : bcnt_q - 16'h0001;
        ph_d    = tick ? ph_q + 4'h1 : ph_q;
        if (rd_ev) begin
            if (a2 == `UAB_OFF_DATA) begin
                dout_d = dlab ? div_q[7:0] : rhr_q;
                dr_d   = dr_q & dlab;
            end else if (a2 == `UAB_OFF_IEN) begin
                dout_d = dlab ? div_q[15:8] : {4'h0, ier_q};
            end else if (a2 == `UAB_OFF_IID) begin
                dout_d = isr_w;
                if (iid == `UAB_IID_THR) thri_d = 1'b0;
            end else if (a2 == `UAB_OFF_LCTL) begin
                dout_d = lcr_q;
            end else if (a2 == `UAB_OFF_MCTL) begin
                dout_d = {3'b000, mcr_q};
            end else if (a2 == `UAB_OFF_LSTAT) begin
                dout_d = lsr_w;
                {oe_d, pe_d, fe_d, bi_d} = 4'h0;
            end else if (a2 == `UAB_OFF_MSTAT) begin
                dout_d = msr_w;
                msd_d  = 4'h0;
            end else begin
                dout_d = scr_q;
            end
        end
        if (wr_ev) begin
            if (a3 == `UAB_OFF_DATA) begin
                if (dlab) div_d[7:0] = d3;
                else thri_d = 1'b0;
            end else if (a3 == `UAB_OFF_IEN) begin
                if (dlab) div_d[15:8] = d3;
                else ier_d = d3[3:0];
                if (!dlab && d3[1] && !ier_q[1] && !fvalid) thri_d = 1'b1;
            end else if (a3 == `UAB_OFF_IID) begin
                fcr_d = d3 & `UAB_FCTL_KEEP;
                if (d3[1]) dr_d = 1'b0;
            end else if (a3 == `UAB_OFF_LCTL) begin
                lcr_d = d3;
            end else if (a3 == `UAB_OFF_MCTL) begin
                mcr_d = d3[4:0];
            end else if (a3 == `UAB_OFF_SCRATCH) begin
                scr_d = d3;
            end
        end
        // Transmitter: a loaded word waits 8 ticks, then starts on the next bit-phase boundary.
        if (tst_q == TX_IDLE) begin
            if (fvalid) begin
                tsh_d  = fdata;
                tpar_d = parity_bit(fdata, lcr_q);
                tcnt_d = 4'h0;
                tst_d  = TX_WAIT;
            end
        end else if (tick) begin
            tcnt_d = tcnt_q + 4'h1;
            if (tst_q == TX_WAIT) begin
                if (tcnt_q == `UAB_TX_GAP) begin
                    tcnt_d = tcnt_q;
                    if (ph_q == `UAB_PH_LAST) begin
                        tst_d  = TX_START;
                        tcnt_d = 4'h0;
                    end
                end
            end else if (tcnt_q == `UAB_PH_LAST) begin
                if (tst_q == TX_START) begin
                    tst_d  = TX_DATA;
                    tbit_d = 3'd0;
                end else if (tst_q == TX_DATA) begin
                    tsh_d  = {1'b0, tsh_q[7:1]};
                    tbit_d = tbit_q + 3'd1;
                    if (tbit_q == last_bit) begin
                        tst_d  = lcr_q[3] ? TX_PAR : TX_STOP;
                        tbit_d = 3'd0;
                    end
                end else if (tst_q == TX_PAR) begin
                    tst_d = TX_STOP;
                end else if (lcr_q[2] && tbit_q == 3'd0) begin
                    tbit_d = 3'd1;
                end else begin
                    tst_d = TX_IDLE;
                end
            end
        end
        case (tst_d)
            TX_START: txd_d = 1'b0;
            TX_DATA:  txd_d = tsh_d[0];
            TX_PAR:   txd_d = tpar_q;
            default:  txd_d = 1'b1;
        endcase
        txd_d = txd_d & ~lcr_d[6];
        // Receiver: the start edge is confirmed at mid-bit, later bits are sampled 16 ticks apart.
        if (tick) begin
            rcnt_d = rcnt_q + 4'h1;
            case (rst_q)
                RX_IDLE: begin
                    if (!rxs) begin
                        rst_d  = RX_START;
                        rcnt_d = 4'h0;
                    end
                end
                RX_START: begin
                    if (rcnt_q == `UAB_RX_MID) begin
                        rst_d  = rxs ? RX_IDLE : RX_DATA;
                        rcnt_d = 4'h0;
                        rbit_d = 3'd0;
                    end
                end
                RX_DATA: begin
                    if (rcnt_q == `UAB_PH_LAST) begin
                        rsh_d  = {rxs, rsh_q[7:1]};
                        rbit_d = rbit_q + 3'd1;
                        if (rbit_q == last_bit) rst_d = lcr_q[3] ? RX_PAR : RX_STOP;
                    end
                end
                RX_PAR: begin
                    if (rcnt_q == `UAB_PH_LAST) begin
                        rpar_d = rxs;
                        rst_d  = RX_STOP;
                    end
                end
                default: begin
                    if (rcnt_q == `UAB_PH_LAST) begin
                        rx_done = 1'b1;
                        rst_d   = RX_IDLE;
                    end
                end
            endcase
        end
        // Event sets come last so an event in a clearing cycle is kept.
        if (rx_done) begin
            rhr_d = rxw;
            dr_d  = 1'b1;
            oe_d  = oe_d | dr_q;
            fe_d  = fe_d | ~rxs;
            pe_d  = pe_d | (lcr_q[3] & (rpar_q != parity_bit(rxw, lcr_q)));
            bi_d  = bi_d | (rxw == 8'h00 && !rxs && !(lcr_q[3] && rpar_q));
        end
        if (!fvalid && !te_q) thri_d = 1'b1;
        if (mval_q) begin
            msd_d = msd_d | {mcur[3] ^ msp_q[3], msp_q[2] & ~mcur[2], mcur[1:0] ^ msp_q[1:0]};
        end
    end

    // State registers; reset leaves the documented register images.
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            ier_q  <= `UAB_RST_IEN;
            lcr_q  <= `UAB_RST_LCTL;
            mcr_q  <= `UAB_RST_MCTL;
            fcr_q  <= `UAB_RST_FCTL;
            {oe_q, pe_q, fe_q, bi_q, dr_q, thri_q} <= 6'h00;
            msd_q  <= 4'h0;
            mval_q <= 1'b0;
            rdy_q  <= 1'b0;
            txd_q  <= 1'b1;
            te_q   <= 1'b1;
            div_q  <= `UAB_RST_DIV;
            bcnt_q <= `UAB_RST_DIV;
            {scr_q, rhr_q, dout_q, tsh_q, rsh_q} <= 40'h0;
            {ph_q, tcnt_q, rcnt_q, tbit_q, rbit_q, tpar_q, rpar_q} <= 20'h0;
            tst_q  <= TX_IDLE;
            rst_q  <= RX_IDLE;
            msp_q  <= 4'h0;
        end else begin
            {ier_q, lcr_q, mcr_q, fcr_q, scr_q, div_q, dout_q} <= {ier_d, lcr_d, mcr_d, fcr_d, scr_d, div_d, dout_d};
            {rhr_q, dr_q, oe_q, pe_q, fe_q, bi_q, thri_q} <= {rhr_d, dr_d, oe_d, pe_d, fe_d, bi_d, thri_d};
            {tst_q, tsh_q, tpar_q, tbit_q, tcnt_q, txd_q} <= {tst_d, tsh_d, tpar_d, tbit_d, tcnt_d, txd_d};
            {rst_q, rsh_q, rpar_q, rbit_q, rcnt_q} <= {rst_d, rsh_d, rpar_d, rbit_d, rcnt_d};
            {msd_q, msp_q, mval_q, rdy_q, te_q, bcnt_q, ph_q} <= {msd_d, msp_d, mval_d, rdy_d, te_d, bcnt_d, ph_d};
        end
    end

    // Pin outputs; loopback parks the modem outputs and the line at their idle level.
    assign data_o                 = dout_q;
    assign data_oe_o              = ~cs2 & ~rd2;
    assign bus_driver_disable_n_o = ~data_oe_o;
    assign txd_o                  = loop | txd_q;
    assign dtr_n_o                = ~(mcr_q[0] & ~loop);
    assign rts_n_o                = ~(mcr_q[1] & ~loop);
    assign user_output_one_n_o    = ~(mcr_q[2] & ~loop);
    assign user_output_two_n_o    = ~(mcr_q[3] & ~loop);
    assign int_o                  = ~isr_w[0];
    assign recv_dma_ready_n_o     = rdy_q & ~dr_q;
    // Mode 1 holds transmit ready active until the FIFO is full; mode 0 until a word waits.
    assign xmit_dma_ready_n_o     = rdy_q & (m1 ? ~fready : fvalid);

    // Helper: ticks spent between leaving idle and the start bit.
    logic [4:0] gap_q;
    always_ff @(posedge core_clk_i) begin
        gap_q <= (tst_q == TX_WAIT) ? gap_q + 5'(tick) : 5'd0;
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    AST_BAUD_DIV: assert property ((tick && div_q == 16'h0003 && $stable(div_q)) |=> !tick ##1 !tick ##1 tick)
        else $error("divisor of three does not give a tick every three clocks");
    AST_RST_CTRL: assert property (disable iff (1'b0) !rst_n_i |=> ier_q == 4'h0 && lcr_q == 8'h00 && mcr_q == 5'h00 && fcr_q == 8'h00 && isr_w == 8'h01)
        else $error("control registers not cleared by reset");
    AST_RST_LSR: assert property (disable iff (1'b0) !rst_n_i |=> lsr_w == 8'h60)
        else $error("line status not 0x60 after reset");
    AST_RST_MSR: assert property (disable iff (1'b0) !rst_n_i ##1 rst_n_i |-> msr_w[3:0] == 4'h0 && msr_w[7:4] == ~mod2)
        else $error("modem status wrong after reset");
    AST_RST_PINS: assert property (disable iff (1'b0) !rst_n_i |=> txd_o && rts_n_o && dtr_n_o && user_output_one_n_o
                                   && user_output_two_n_o && !recv_dma_ready_n_o && !xmit_dma_ready_n_o)
        else $error("pin levels wrong during reset");
    AST_RX_INT: assert property ((rx_done && ier_q[0]) |=> int_o && dr_q)
        else $error("receive interrupt late after stop bit");
    AST_TX_GAP: assert property ((tst_q == TX_WAIT && tst_d == TX_START) |-> gap_q >= 5'd8 && gap_q <= 5'd24)
        else $error("start bit outside 8 to 24 ticks");
    AST_RX_RDY: assert property (rx_done |=> !recv_dma_ready_n_o ##1 (!recv_dma_ready_n_o || !dr_q))
        else $error("receive ready not asserted after stop bit");
    AST_TX_RDY: assert property ((tst_q == TX_START && !m1 && !fvalid) |-> !xmit_dma_ready_n_o)
        else $error("transmit ready not active during start bit");
endmodule : uab_core
`default_nettype wire

//--- logic/uab_pkg.sv
// Types shared by the serial transceiver core.
// Assumes nothing of its surroundings.
package uab_pkg;
    typedef enum logic [2:0] {TX_IDLE, TX_WAIT, TX_START, TX_DATA, TX_PAR, TX_STOP} uab_tx_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} uab_rx_t;
endpackage : uab_pkg

//--- logic/uab_regs.svh
// Register offsets, reset values and timing counts of the serial transceiver core.
// Assumes it is included by bare name from the design files; holds definitions only.
`ifndef UAB_REGS_SVH
`define UAB_REGS_SVH

`define UAB_OFF_DATA    3'h0
`define UAB_OFF_IEN     3'h1
`define UAB_OFF_IID     3'h2
`define UAB_OFF_LCTL    3'h3
`define UAB_OFF_MCTL    3'h4
`define UAB_OFF_LSTAT   3'h5
`define UAB_OFF_MSTAT   3'h6
`define UAB_OFF_SCRATCH 3'h7

`define UAB_RST_IEN     4'h0
`define UAB_RST_LCTL    8'h00
`define UAB_RST_MCTL    5'h00
`define UAB_RST_FCTL    8'h00
`define UAB_RST_DIV     16'h0001
`define UAB_FCTL_KEEP   8'h09

`define UAB_IID_NONE    4'h1
`define UAB_IID_LINE    4'h6
`define UAB_IID_RXD     4'h4
`define UAB_IID_THR     4'h2
`define UAB_IID_MODEM   4'h0

`define UAB_TX_GAP      4'h8
`define UAB_PH_LAST     4'hF
`define UAB_RX_MID      4'h7

`endif

//--- test/tb.sv
// Self-checking bench for the serial transceiver core.
// Assumes uab_peer on the serial pins and the register pins driven as slow async strobes.
`timescale 1ns/1ps
`default_nettype none
`include "uab_regs.svh"
module tb;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        cs_n = 1'b1;
    logic        rd_n = 1'b1;
    logic        wr_n = 1'b1;
    logic [2:0]  addr = 3'h0;
    logic [7:0]  wdat = 8'h00;
    logic [3:0]  mdm_n = 4'hF;
    logic [7:0]  rdat;
    logic        rxd, txd, rts_n, dtr_n, op1_n, op2_n, irq, rxr_n, txr_n;
    logic [15:0] div = 16'h0001;
    int          n_mismatch = 0;
    int          checks_done = 0;

    uab_core DUT (.core_clk_i(clk), .rst_n_i(rst_n), .chip_select_n_i(cs_n), .addr_i(addr),
        .data_i(wdat), .data_o(rdat), .data_oe_o(), .read_strobe_n_i(rd_n),
        .write_strobe_n_i(wr_n), .bus_driver_disable_n_o(), .rxd_i(rxd), .txd_o(txd),
        .cts_n_i(mdm_n[0]), .dsr_n_i(mdm_n[1]), .ri_n_i(mdm_n[2]), .cd_n_i(mdm_n[3]),
        .rts_n_o(rts_n), .dtr_n_o(dtr_n), .user_output_one_n_o(op1_n),
        .user_output_two_n_o(op2_n), .int_o(irq), .recv_dma_ready_n_o(rxr_n),
        .xmit_dma_ready_n_o(txr_n));
    uab_peer P (.clk_i(clk), .line_i(txd), .line_o(rxd));

    // Free-running 125 MHz clock.
    initial forever #4 clk = ~clk;

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk

    // Start bit must fall 9 to 24 ticks after the word is popped, counted from the write's end.
    function automatic logic [7:0] gap_ok(input int n, input int d);
        return 8'(n >= 9 * d - 3 && n <= 24 * d + 2);
    endfunction : gap_ok

    task automatic close_out();
        if (n_mismatch == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : close_out

    // One pin-level access; strobes stay low five clocks so the synchronisers see them.
    task automatic bus(input logic wr, input logic [2:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        cs_n <= 1'b0;
        addr <= a;
        wdat <= d;
        @(posedge clk);
        if (wr) wr_n <= 1'b0;
        else rd_n <= 1'b0;
        repeat (5) @(posedge clk);
        q = rdat;
        wr_n <= 1'b1;
        rd_n <= 1'b1;
        repeat (2) @(posedge clk);
        cs_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask : bus

    // Main sequence: reset state, then random characters both ways at small divisors.
    initial begin
        logic [7:0] q, b, got;
        int         sw, n;
        void'($urandom(11882));
        mdm_n <= 4'($urandom);
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk({3'h0, txd, rts_n, dtr_n, op1_n, op2_n}, 8'h1F);
        chk({6'h0, rxr_n, txr_n}, 8'h00);
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        bus(1'b0, `UAB_OFF_IEN, 8'h00, q); chk(q, 8'h00);
        bus(1'b0, `UAB_OFF_IID, 8'h00, q); chk(q, 8'h01);
        bus(1'b0, `UAB_OFF_LCTL, 8'h00, q); chk(q, 8'h00);
        bus(1'b0, `UAB_OFF_MCTL, 8'h00, q); chk(q, 8'h00);
        bus(1'b0, `UAB_OFF_LSTAT, 8'h00, q); chk(q, 8'h60);
        bus(1'b0, `UAB_OFF_MSTAT, 8'h00, q); chk(q, {~mdm_n, 4'h0});
        for (int k = 0; k < 4; k++) begin
            div = (k == 0) ? 16'h0001 : (k == 1) ? 16'h0003 : 16'(1 + $urandom_range(2));
            bus(1'b1, `UAB_OFF_LCTL, 8'h83, q);
            bus(1'b1, `UAB_OFF_DATA, div[7:0], q);
            bus(1'b1, `UAB_OFF_IEN, div[15:8], q);
            bus(1'b1, `UAB_OFF_LCTL, 8'h03, q);
            bus(1'b1, `UAB_OFF_IEN, 8'h01, q);
            b = 8'($urandom) | 8'h01;
            bus(1'b1, `UAB_OFF_DATA, b, q);
            // Start bit timing is judged here while the peer decodes the frame.
            fork
                P.recv(div, got, sw);
                begin
                    n = 0;
                    while (txd !== 1'b0 && n < 2000) begin
                        @(negedge clk);
                        n++;
                    end
                    if (n >= 2000) begin
                        n_mismatch++;
                        close_out();
                    end
                    chk(gap_ok(n, int'(div)), 8'h01);
                    repeat (8 * div) @(negedge clk);
                    chk({7'h0, txr_n}, 8'h00);
                end
            join
            chk(got, b);
            chk(8'(sw), 8'(16 * div));
            b = 8'($urandom);
            @(posedge clk);
            P.send(div, b);
            chk({6'h0, irq, rxr_n}, 8'h02);
            bus(1'b0, `UAB_OFF_IID, 8'h00, q); chk(q, 8'h04);
            bus(1'b0, `UAB_OFF_DATA, 8'h00, q); chk(q, b);
            chk({7'h0, rxr_n}, 8'h01);
        end
        // Mid-run reset with dirty control registers and a break on the line.
        bus(1'b1, `UAB_OFF_MCTL, 8'h0F, q);
        bus(1'b1, `UAB_OFF_LCTL, 8'h5B, q);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk({3'h0, txd, rts_n, dtr_n, op1_n, op2_n}, 8'h1F);
        chk({6'h0, rxr_n, txr_n}, 8'h00);
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        bus(1'b0, `UAB_OFF_IEN, 8'h00, q); chk(q, 8'h00);
        bus(1'b0, `UAB_OFF_LCTL, 8'h00, q); chk(q, 8'h00);
        bus(1'b0, `UAB_OFF_MCTL, 8'h00, q); chk(q, 8'h00);
        bus(1'b0, `UAB_OFF_LSTAT, 8'h00, q); chk(q, 8'h60);
        close_out();
    end
endmodule : tb
`default_nettype wire

//--- test/uab_peer.sv
// Serial far end: drives the receive line and decodes the transmit line.
// Assumes 8 data bits, no parity, one stop bit, and 16 clocks per bit per divisor step.
`timescale 1ns/1ps
`default_nettype none
module uab_peer (
    input  wire logic clk_i,
    input  wire logic line_i,
    output var logic  line_o
);
    // The line idles at mark, so a released line reads as high.
    initial line_o = 1'b1;

    // Sends one frame; the caller enters just after a rising edge.
    task automatic send(input logic [15:0] div, input logic [7:0] b);
        logic [9:0] fr;
        fr = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            line_o <= fr[i];
            repeat (16 * div) @(posedge clk_i);
        end
    endtask : send

    // Measures the start bit, then samples each data bit at its centre.
    task automatic recv(input logic [15:0] div, output logic [7:0] b, output int width);
        int n;
        n = 0;
        width = 0;
        while (line_i !== 1'b0 && n < 4000) begin
            @(negedge clk_i);
            n++;
        end
        while (line_i === 1'b0 && width < 4000) begin
            @(negedge clk_i);
            width++;
        end
        repeat (8 * div) @(negedge clk_i);
        for (int i = 0; i < 8; i++) begin
            b[i] = line_i;
            repeat (16 * div) @(negedge clk_i);
        end
    endtask : recv
endmodule : uab_peer
`default_nettype wire
